//--- logic/tdr_results_pkg.sv
package tdr_results_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int AMP_W = 7;
   localparam int PEAK_N = 5;

   localparam logic [ADDR_W-1:0] ADDR_AMP_RESULTS_3 = 16'h0187;
   localparam logic [ADDR_W-1:0] ADDR_AMP_RESULTS_4 = 16'h0188;
   localparam logic [ADDR_W-1:0] ADDR_AMP_RESULTS_5 = 16'h0189;
   localparam logic [ADDR_W-1:0] ADDR_GENERAL_RESULTS = 16'h018A;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 16'h0190;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 16'h0191;
   localparam logic [ADDR_W-1:0] ADDR_DIAG_STATE = 16'h0192;

   localparam int AMP_HI_LSB = 8;
   localparam int AMP_LO_LSB = 0;
   localparam int GEN_TX_POL_LSB = 11;
   localparam int GEN_RX_POL_LSB = 6;
   localparam int GEN_CROSS_TX_BIT = 5;
   localparam int GEN_CROSS_RX_BIT = 4;
   localparam int GEN_OVER_TX_BIT = 3;
   localparam int GEN_OVER_RX_BIT = 2;

   localparam int EV_W = 6;
   localparam int EV_RUN_DONE = 0;
   localparam int EV_CROSS_TX = 1;
   localparam int EV_CROSS_RX = 2;
   localparam int EV_OVER_TX = 3;
   localparam int EV_OVER_RX = 4;
   localparam int EV_TIMEOUT = 5;
   localparam logic [EV_W-1:0] IRQ_MASK_RESET = 6'h00;

   localparam int STATE_DONE_BIT = 0;
   localparam int STATE_BUSY_BIT = 1;

   localparam int CLK_FREQ_MHZ = 40;
   localparam int RUN_TIMEOUT_US = 100;
   localparam int RUN_TIMEOUT_CYCLES = RUN_TIMEOUT_US * CLK_FREQ_MHZ;
   localparam int TIMER_W = 16;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_DONE = 3'b100
   } run_state_type;

   typedef struct packed {
      logic [PEAK_N-1:0][AMP_W-1:0] tx_amp;
      logic [PEAK_N-1:0][AMP_W-1:0] rx_amp;
      logic [PEAK_N-1:0] tx_pol;
      logic [PEAK_N-1:0] rx_pol;
      logic cross_tx;
      logic cross_rx;
      logic over_tx;
      logic over_rx;
   } tdr_result_type;

   localparam tdr_result_type RESULT_RESET = '0;

   typedef struct packed {
      run_state_type state;
      tdr_result_type result;
      logic [EV_W-1:0] mask;
      logic [TIMER_W-1:0] timer;
      logic done;
      logic busy;
      logic irq;
      logic rd_valid;
      logic [DATA_W-1:0] rd_data;
   } bank_state_type;

   typedef struct packed {
      logic [EV_W-1:0] flags;
   } flag_state_type;

endpackage : tdr_results_pkg

//--- logic/sticky_event_flags.sv
`timescale 1ns/100ps
module sticky_event_flags
   import tdr_results_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [EV_W-1:0] set_i,
   input wire logic [EV_W-1:0] clr_i,
   output logic [EV_W-1:0] flags_o
);

   flag_state_type st_reg;
   flag_state_type st_next;

   // A set arriving with a write-one clear keeps the flag set.
   always_comb begin
      st_next = st_reg;
      for (int i = 0; i < EV_W; i++) begin
         st_next.flags[i] = set_i[i] | (st_reg.flags[i] & ~clr_i[i]);
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign flags_o = st_reg.flags;

endmodule : sticky_event_flags

//--- logic/cable_tdr_result_registers.sv
`timescale 1ns/100ps
// Functional notes
// - Amplitude bits 15 and 7 read zero.
// - 0x0187: receive peak 1, transmit peak 5.
// - 0x0188: receive peak 3, receive peak 2.
// - 0x0189: receive peak 5, receive peak 4.
// - Amplitude fields read-only, reset to zero.
// - General bits 15:11, 10:6 hold peak polarities.
// - Bit 5 flags transmit pair cross reflection.
// - Bit 4 flags receive pair cross reflection.
// - Bits 3, 2 flag over five reflections.
module cable_tdr_result_registers
   import tdr_results_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = RUN_TIMEOUT_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   output logic [DATA_W-1:0] rd_data_o,
   output logic rd_valid_o,
   input wire logic diag_start_i,
   input wire logic result_valid_i,
   input wire tdr_result_type result_i,
   output logic diag_done_o,
   output logic diag_busy_o,
   output logic irq_o
);

   localparam logic [TIMER_W-1:0] TIMEOUT_LAST = TIMER_W'(TIMEOUT_CYCLES - 1);

   bank_state_type st_reg;
   bank_state_type st_next;
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] ev_clr;
   logic [EV_W-1:0] ev_flags;

   function automatic logic [DATA_W-1:0] amp_pair(
      input logic [AMP_W-1:0] hi,
      input logic [AMP_W-1:0] lo
   );
      logic [DATA_W-1:0] r;
      r = '0;
      r[AMP_HI_LSB +: AMP_W] = hi;
      r[AMP_LO_LSB +: AMP_W] = lo;
      // Bits 15 and 7 stay at zero.
      return r;
   endfunction : amp_pair

   function automatic logic [DATA_W-1:0] read_mux(
      input logic [ADDR_W-1:0] addr,
      input bank_state_type s,
      input logic [EV_W-1:0] flags
   );
      logic [DATA_W-1:0] r;
      r = '0;
      case (addr)
         ADDR_AMP_RESULTS_3: begin
            r = amp_pair(s.result.rx_amp[0], s.result.tx_amp[4]);
         end
         ADDR_AMP_RESULTS_4: begin
            r = amp_pair(s.result.rx_amp[2], s.result.rx_amp[1]);
         end
         ADDR_AMP_RESULTS_5: begin
            r = amp_pair(s.result.rx_amp[4], s.result.rx_amp[3]);
         end
         ADDR_GENERAL_RESULTS: begin
            r[GEN_TX_POL_LSB +: PEAK_N] = s.result.tx_pol;
            r[GEN_RX_POL_LSB +: PEAK_N] = s.result.rx_pol;
            r[GEN_CROSS_TX_BIT] = s.result.cross_tx;
            r[GEN_CROSS_RX_BIT] = s.result.cross_rx;
            r[GEN_OVER_TX_BIT] = s.result.over_tx;
            r[GEN_OVER_RX_BIT] = s.result.over_rx;
         end
         ADDR_IRQ_STATUS: begin
            r[EV_W-1:0] = flags;
         end
         ADDR_IRQ_MASK: begin
            r[EV_W-1:0] = s.mask;
         end
         ADDR_DIAG_STATE: begin
            r[STATE_DONE_BIT] = s.done;
            r[STATE_BUSY_BIT] = s.busy;
         end
         default: begin
            r = '0;
         end
      endcase
      return r;
   endfunction : read_mux

   always_comb begin
      st_next = st_reg;
      ev_set = '0;
      ev_clr = '0;
      st_next.rd_valid = 1'b0;
      st_next.rd_data = '0;

      case (st_reg.state)
         ST_IDLE, ST_DONE: begin
            if (diag_start_i) begin
               // A new run drops the previous results so no stale peak survives.
               st_next.state = ST_RUN;
               st_next.result = RESULT_RESET;
               st_next.done = 1'b0;
               st_next.busy = 1'b1;
               st_next.timer = '0;
            end
         end
         ST_RUN: begin
            if (result_valid_i) begin
               // Results and done land on the same edge, so done never leads data.
               st_next.result = result_i;
               st_next.state = ST_DONE;
               st_next.done = 1'b1;
               st_next.busy = 1'b0;
               ev_set[EV_RUN_DONE] = 1'b1;
               ev_set[EV_CROSS_TX] = result_i.cross_tx;
               ev_set[EV_CROSS_RX] = result_i.cross_rx;
               ev_set[EV_OVER_TX] = result_i.over_tx;
               ev_set[EV_OVER_RX] = result_i.over_rx;
            end else if (st_reg.timer == TIMEOUT_LAST) begin
               st_next.state = ST_IDLE;
               st_next.busy = 1'b0;
               ev_set[EV_TIMEOUT] = 1'b1;
            end else begin
               st_next.timer = st_reg.timer + 1'b1;
            end
         end
         default: begin
            st_next.state = ST_IDLE;
            st_next.busy = 1'b0;
            st_next.done = 1'b0;
         end
      endcase

      // Writes to the result registers fall through and change nothing.
      if (wr_en_i) begin
         case (addr_i)
            ADDR_IRQ_STATUS: begin
               ev_clr = wr_data_i[EV_W-1:0];
            end
            ADDR_IRQ_MASK: begin
               st_next.mask = wr_data_i[EV_W-1:0];
            end
            default: begin
               ev_clr = '0;
            end
         endcase
      end

      if (rd_en_i) begin
         st_next.rd_valid = 1'b1;
         st_next.rd_data = read_mux(addr_i, st_reg, ev_flags);
      end

      st_next.irq = |(ev_flags & st_reg.mask);
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg.state <= ST_IDLE;
         st_reg.result <= RESULT_RESET;
         st_reg.mask <= IRQ_MASK_RESET;
         st_reg.timer <= '0;
         st_reg.done <= 1'b0;
         st_reg.busy <= 1'b0;
         st_reg.irq <= 1'b0;
         st_reg.rd_valid <= 1'b0;
         st_reg.rd_data <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   sticky_event_flags u_flags (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .set_i(ev_set),
      .clr_i(ev_clr),
      .flags_o(ev_flags)
   );

   assign rd_data_o = st_reg.rd_data;
   assign rd_valid_o = st_reg.rd_valid;
   assign diag_done_o = st_reg.done;
   assign diag_busy_o = st_reg.busy;
   assign irq_o = st_reg.irq;

endmodule : cable_tdr_result_registers

//--- dv/cable_tdr_result_registers_checker.sv
`timescale 1ns/100ps
module cable_tdr_result_registers_checker
   import tdr_results_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [DATA_W-1:0] rd_data_o,
   input wire logic rd_valid_o,
   input wire logic diag_start_i,
   input wire logic result_valid_i,
   input wire tdr_result_type result_i,
   input wire logic diag_done_o,
   input wire logic diag_busy_o,
   input wire logic irq_o
);
   // Copy of the last captured result, for comparing reads against it.
   tdr_result_type cap_reg;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) cap_reg <= RESULT_RESET;
      else if (result_valid_i && diag_busy_o) cap_reg <= result_i;
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_rd; rd_en_i |=> rd_valid_o; endproperty
   a_rd: assert property (p_rd) else $error("read valid missing");
   property p_nord; !rd_en_i |=> !rd_valid_o && rd_data_o == '0; endproperty
   a_nord: assert property (p_nord) else $error("read data not idle");
   property p_rsv; rd_en_i && addr_i inside {[16'h0187:16'h0189]}
      |=> rd_data_o[15] == 1'b0 && rd_data_o[7] == 1'b0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_amp3; rd_en_i && addr_i == ADDR_AMP_RESULTS_3 && diag_done_o
      |=> rd_data_o[14:0] == {cap_reg.rx_amp[0], 1'b0, cap_reg.tx_amp[4]}; endproperty
   a_amp3: assert property (p_amp3) else $error("amplitude word wrong");
   property p_pol; rd_en_i && addr_i == ADDR_GENERAL_RESULTS && diag_done_o
      |=> rd_data_o[15:6] == {cap_reg.tx_pol, cap_reg.rx_pol}; endproperty
   a_pol: assert property (p_pol) else $error("polarity wrong");
   property p_gen; rd_en_i && addr_i == ADDR_GENERAL_RESULTS && diag_done_o
      |=> rd_data_o[5:0] == {cap_reg.cross_tx, cap_reg.cross_rx,
         cap_reg.over_tx, cap_reg.over_rx, 2'b00}; endproperty
   a_gen: assert property (p_gen) else $error("flags wrong");
   property p_start; diag_start_i && !diag_busy_o |=> diag_busy_o && !diag_done_o; endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_cap; result_valid_i && diag_busy_o ##1 1'b1 |-> diag_done_o && !diag_busy_o;
   endproperty
   a_cap: assert property (p_cap) else $error("capture not done");
   property p_hold; diag_done_o && !diag_start_i |=> $stable(diag_done_o); endproperty
   a_hold: assert property (p_hold) else $error("done dropped");
endmodule : cable_tdr_result_registers_checker

bind cable_tdr_result_registers cable_tdr_result_registers_checker chk_i (
   .core_clk_i(core_clk_i),
   .rstn_i(rstn_i),
   .addr_i(addr_i),
   .wr_data_i(wr_data_i),
   .wr_en_i(wr_en_i),
   .rd_en_i(rd_en_i),
   .rd_data_o(rd_data_o),
   .rd_valid_o(rd_valid_o),
   .diag_start_i(diag_start_i),
   .result_valid_i(result_valid_i),
   .result_i(result_i),
   .diag_done_o(diag_done_o),
   .diag_busy_o(diag_busy_o),
   .irq_o(irq_o)
);

//--- dv/cable_tdr_result_registers_tb_top.sv
`timescale 1ns/100ps
module cable_tdr_result_registers_tb_top import tdr_results_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wr_data_i = '0;
   logic wr_en_i = 1'b0;
   logic rd_en_i = 1'b0;
   logic diag_start_i = 1'b0;
   logic result_valid_i = 1'b0;
   tdr_result_type result_i = RESULT_RESET;
   logic [DATA_W-1:0] rd_data_o;
   logic rd_valid_o, diag_done_o, diag_busy_o, irq_o;
   int miscompares = 0;
   int n_checks = 0;
   int seed = 32'h35a8d7f8;
   tdr_result_type res;
   logic [95:0] t;
   always #12.5 core_clk_i = ~core_clk_i;
   cable_tdr_result_registers #(
      .TIMEOUT_CYCLES(20)
   ) dut (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .addr_i(addr_i),
      .wr_data_i(wr_data_i),
      .wr_en_i(wr_en_i),
      .rd_en_i(rd_en_i),
      .rd_data_o(rd_data_o),
      .rd_valid_o(rd_valid_o),
      .diag_start_i(diag_start_i),
      .result_valid_i(result_valid_i),
      .result_i(result_i),
      .diag_done_o(diag_done_o),
      .diag_busy_o(diag_busy_o),
      .irq_o(irq_o)
   );
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_en_i <= 1'b1;
      @(posedge core_clk_i);
      wr_en_i <= 1'b0;
   endtask : wr
   task rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_en_i <= 1'b1;
      @(posedge core_clk_i);
      rd_en_i <= 1'b0;
      #1 chk("rd_data", rd_data_o, e);
      chk("rd_valid", 16'(rd_valid_o), 16'h0001);
   endtask : rd
   function logic [15:0] ex(input logic [15:0] a, input tdr_result_type r);
      case (a)
         ADDR_AMP_RESULTS_3: ex = {1'b0, r.rx_amp[0], 1'b0, r.tx_amp[4]};
         ADDR_AMP_RESULTS_4: ex = {1'b0, r.rx_amp[2], 1'b0, r.rx_amp[1]};
         ADDR_AMP_RESULTS_5: ex = {1'b0, r.rx_amp[4], 1'b0, r.rx_amp[3]};
         ADDR_GENERAL_RESULTS: ex = {r.tx_pol, r.rx_pol, r.cross_tx, r.cross_rx,
            r.over_tx, r.over_rx, 2'b00};
         default: ex = 16'h0000;
      endcase
   endfunction : ex
   task run(input tdr_result_type r);
      @(posedge core_clk_i);
      result_i <= r;
      diag_start_i <= 1'b1;
      @(posedge core_clk_i);
      diag_start_i <= 1'b0;
      result_valid_i <= 1'b1;
      #1 chk("busy", 16'(diag_busy_o), 16'h0001);
      @(posedge core_clk_i);
      result_valid_i <= 1'b0;
      #1 chk("done", 16'({diag_busy_o, diag_done_o}), 16'h0001);
   endtask : run
   initial begin
      repeat (10) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         rd(ADDR_AMP_RESULTS_3 + 16'(k), 16'h0000);
         wr(ADDR_AMP_RESULTS_3 + 16'(k), 16'hFFFF);
         rd(ADDR_AMP_RESULTS_3 + 16'(k), 16'h0000);
      end
      rd(16'h0200, 16'h0000);
      wr(ADDR_IRQ_MASK, 16'h003F);
      rd(ADDR_IRQ_MASK, 16'h003F);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         t = {$random(seed), $random(seed), $random(seed)};
         res = t[83:0];
         run(res);
         @(posedge core_clk_i);
         result_i <= ~res;
         result_valid_i <= 1'b1;
         @(posedge core_clk_i);
         result_valid_i <= 1'b0;
         rd(ADDR_DIAG_STATE, 16'h0001);
         for (int k = 0; k < 4; k++)
            rd(ADDR_AMP_RESULTS_3 + 16'(k), ex(ADDR_AMP_RESULTS_3 + 16'(k), res));
         rd(ADDR_IRQ_STATUS, {11'h000, res.over_rx, res.over_tx, res.cross_rx,
            res.cross_tx, 1'b1});
         chk("irq", 16'(irq_o), 16'h0001);
         wr(ADDR_IRQ_STATUS, 16'h003F);
         @(posedge core_clk_i);
         #1 chk("irq", 16'(irq_o), 16'h0000);
      end
      $display("test runs done");
      @(posedge core_clk_i);
      diag_start_i <= 1'b1;
      @(posedge core_clk_i);
      diag_start_i <= 1'b0;
      rd(ADDR_GENERAL_RESULTS, 16'h0000);
      for (int i = 0; i < 40 && diag_busy_o === 1'b1; i++) begin
         @(posedge core_clk_i);
         #1;
      end
      if (diag_busy_o !== 1'b0) begin
         miscompares++;
      end else begin
         chk("done", 16'(diag_done_o), 16'h0000);
         rd(ADDR_DIAG_STATE, 16'h0000);
         rd(ADDR_IRQ_STATUS, 16'h0020);
         wr(ADDR_IRQ_MASK, 16'h0000);
         run(res);
         @(posedge core_clk_i);
         #1 chk("irq", 16'(irq_o), 16'h0000);
      end
      $display("test timeout and mask done");
      report_and_stop();
   end
endmodule : cable_tdr_result_registers_tb_top
